// ---- logic/hlci_pkg.sv ----
// Overview of operation
// - Inputs ignored unless request line held; start low still clears the ended output without it
// - Zero program number: start is emission enable
// - Nonzero number: start rising edge launches program
// - Power from program, else analog when enabled
// - Internal control enable hands over to software
// - Alarm reset rising edge clears latched alarm
// - Guide light follows guide light input
// - Analog enable opens analog input, number zero; ANALOG_INPUT_ENABLE follows it for any number
// - Program stop input ends running program immediately
// - Seven select inputs form number, first is LSB
// - Running output high exactly while program executes
// - Ended output set at finish, cleared start low
// - Abnormal output set on fault, cleared alarm reset
// - Acknowledge output high while request is received
package hlci_pkg;

  // Positions of the hardwired inputs in the sampled vector
  localparam int IN_W        = 14;
  localparam int IN_REQUEST  = 0;
  localparam int IN_START    = 1;
  localparam int IN_INTCTL   = 2;
  localparam int IN_ALRST    = 3;
  localparam int IN_GUIDE    = 4;
  localparam int IN_ANALOG   = 5;
  localparam int IN_STOP     = 6;
  localparam int IN_PROG_LSB = 7;
  localparam int PROG_W      = 7;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;

  // Field positions
  localparam int CTRL_PORT_EN  = 0;
  localparam int STAT_RUN      = 16;
  localparam int STAT_ENDED    = 17;
  localparam int STAT_ABNORMAL = 18;
  localparam int STAT_ALARM    = 19;
  localparam int EV_LAUNCH     = 0;
  localparam int EV_ENDED      = 1;
  localparam int EV_ABNORMAL   = 2;
  localparam int EV_ALRST      = 3;
  localparam int EV_W          = 4;

  // Reset values
  localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Program sequencer states
  typedef enum logic [0:0] {
    HLCI_IDLE = 1'b0,
    HLCI_RUN  = 1'b1
  } hlci_state_e;

endpackage : hlci_pkg

// ---- logic/hlci_top.sv ----
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module hlci_top
#(
  parameter int ADDR_W = 8                        // Register address width
)
(
  input  wire logic              CLK_SYS,
  input  wire logic              RST_B,
  // Hardwired control connector inputs
  input  wire logic              REQUEST_LINE,
  input  wire logic              START_LINE,
  input  wire logic              INTERNAL_CONTROL_ENABLE,
  input  wire logic              ALARM_RESET_INPUT,
  input  wire logic              GUIDE_LIGHT_INPUT,
  input  wire logic              ANALOG_ENABLE,
  input  wire logic              PROGRAM_STOP_INPUT,
  input  wire logic [6:0]        PROGRAM_SELECT_INPUTS,
  // Program engine and alarm source on the same clock
  input  wire logic              PROG_DONE_IN,
  input  wire logic              PROG_FAULT_IN,
  input  wire logic              ALARM_EVENT_IN,
  // Hardwired status outputs
  output logic                   REQUEST_ACKNOWLEDGE_OUTPUT,
  output logic                   PROGRAM_RUNNING_OUTPUT,
  output logic                   PROGRAM_ENDED_OUTPUT,
  output logic                   ABNORMAL_TERMINATION_OUTPUT,
  // Internal controls
  output logic                   EMISSION_ENABLE,
  output logic                   PROGRAM_LAUNCH,
  output logic                   PROGRAM_ABORT,
  output logic [6:0]             PROGRAM_NUMBER,
  output logic                   POWER_FROM_PROGRAM,
  output logic                   POWER_FROM_ANALOG,
  output logic                   ANALOG_INPUT_ENABLE,
  output logic                   SOFTWARE_CONTROL,
  output logic                   GUIDE_LIGHT_ON,
  output logic                   ALARM_LATCHED,
  output logic                   IRQ,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);

  // Register select: 0 ctrl, 1 status, 2 irq status, 3 irq mask, 4 unmapped
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    case (a)
      hlci_pkg::OFF_CTRL:     reg_sel = 3'h0;
      hlci_pkg::OFF_STATUS:   reg_sel = 3'h1;
      hlci_pkg::OFF_IRQ_STAT: reg_sel = 3'h2;
      hlci_pkg::OFF_IRQ_MASK: reg_sel = 3'h3;
      default:                reg_sel = 3'h4;
    endcase
  endfunction : reg_sel

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction : merge

  localparam int N = hlci_pkg::IN_W;

  logic [N-1:0] raw;                               // Pin vector
  logic [N-1:0] s1_q;                              // First synchroniser stage
  logic [N-1:0] s2_q;                              // Second stage
  logic [N-1:0] s3_q;                              // Third stage
  logic [N-1:0] filt_q;                            // Debounced level
  logic [N-1:0] prev_q;                            // Debounced level, one cycle late
  logic [N-1:0] rise;                              // Debounced rising edges
  logic [N-1:0] fall;                              // Debounced falling edges

  assign raw = {PROGRAM_SELECT_INPUTS, PROGRAM_STOP_INPUT, ANALOG_ENABLE, GUIDE_LIGHT_INPUT,
                ALARM_RESET_INPUT, INTERNAL_CONTROL_ENABLE, START_LINE, REQUEST_LINE};

  // Three-stage synchroniser for all pins
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Debounce: a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_deb
      always_ff @(posedge CLK_SYS)
      begin
        if (!RST_B)
        begin
          filt_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end
        else
        begin
          if (s2_q[gi] == s3_q[gi])
          begin
            filt_q[gi] <= s3_q[gi];
          end
          prev_q[gi] <= filt_q[gi];
        end
      end
    end
  endgenerate

  // One edge event per debounced transition
  assign rise = filt_q & ~prev_q;
  assign fall = ~filt_q & prev_q;

  logic [31:0]                 ctrl_q;             // Control register
  logic [hlci_pkg::EV_W-1:0]   irq_stat_q;         // Sticky event bits
  logic [hlci_pkg::EV_W-1:0]   irq_mask_q;         // Event mask
  logic                        gate;               // Port enabled and request held
  logic [6:0]                  prog;               // Selected program number
  logic                        prog_zero;          // Program number is zero
  logic                        start_lvl;          // Gated start level
  hlci_pkg::hlci_state_e       state_q;            // Sequencer state
  logic                        launch;             // Program launch this cycle
  logic                        ev_fault;           // Abnormal end this cycle
  logic                        ev_stop;            // Normal end this cycle
  logic                        ended_q;            // Program ended flag
  logic                        abn_q;              // Abnormal end flag
  logic                        alarm_q;            // Latched alarm
  logic                        alrst_rise;         // Gated alarm reset edge

  // Inputs only count while the port is enabled and request is held, except start low clearing ended_q
  assign gate       = ctrl_q[hlci_pkg::CTRL_PORT_EN] & filt_q[hlci_pkg::IN_REQUEST];
  assign prog       = filt_q[hlci_pkg::IN_PROG_LSB +: hlci_pkg::PROG_W];
  assign prog_zero  = (prog == 7'h00);
  assign start_lvl  = gate & filt_q[hlci_pkg::IN_START];
  assign alrst_rise = gate & rise[hlci_pkg::IN_ALRST];
  assign launch     = (state_q == hlci_pkg::HLCI_IDLE) & gate & rise[hlci_pkg::IN_START]
                      & ~prog_zero;
  // Fault, or start dropped mid-program, ends abnormally
  assign ev_fault   = (state_q == hlci_pkg::HLCI_RUN)
                      & (PROG_FAULT_IN | (gate & fall[hlci_pkg::IN_START]));
  // Stop input, done, or lost request ends the program
  assign ev_stop    = (state_q == hlci_pkg::HLCI_RUN) & ~ev_fault
                      & (PROG_DONE_IN | ~gate | filt_q[hlci_pkg::IN_STOP]);

  // Program sequencer
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      state_q <= hlci_pkg::HLCI_IDLE;
    end
    else
    begin
      case (state_q)
        hlci_pkg::HLCI_IDLE:
        begin
          if (launch)
          begin
            state_q <= hlci_pkg::HLCI_RUN;
          end
        end
        hlci_pkg::HLCI_RUN:
        begin
          if (ev_fault | ev_stop)
          begin
            state_q <= hlci_pkg::HLCI_IDLE;
          end
        end
        default:
        begin
          state_q <= hlci_pkg::HLCI_IDLE;
        end
      endcase
    end
  end

  // Ended and abnormal flags; a set wins over a clear
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      ended_q <= 1'b0;
      abn_q   <= 1'b0;
    end
    else
    begin
      ended_q <= ev_stop | (ended_q & filt_q[hlci_pkg::IN_START]);
      abn_q   <= ev_fault | (abn_q & ~(gate & filt_q[hlci_pkg::IN_ALRST]));
    end
  end

  // Latched alarm, cleared on a gated alarm reset edge
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      alarm_q <= 1'b0;
    end
    else
    begin
      alarm_q <= ALARM_EVENT_IN | (alarm_q & ~alrst_rise);
    end
  end

  // Registered control and status outputs
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      REQUEST_ACKNOWLEDGE_OUTPUT  <= 1'b0;
      EMISSION_ENABLE             <= 1'b0;
      PROGRAM_LAUNCH              <= 1'b0;
      PROGRAM_ABORT               <= 1'b0;
      PROGRAM_NUMBER              <= 7'h00;
      POWER_FROM_PROGRAM          <= 1'b0;
      POWER_FROM_ANALOG           <= 1'b0;
      ANALOG_INPUT_ENABLE         <= 1'b0;
      SOFTWARE_CONTROL            <= 1'b0;
      GUIDE_LIGHT_ON              <= 1'b0;
    end
    else
    begin
      REQUEST_ACKNOWLEDGE_OUTPUT  <= gate;
      EMISSION_ENABLE             <= start_lvl & prog_zero;
      PROGRAM_LAUNCH              <= launch;
      PROGRAM_ABORT               <= ev_fault | (ev_stop & ~PROG_DONE_IN);
      PROGRAM_NUMBER              <= gate ? prog : 7'h00;
      POWER_FROM_PROGRAM          <= gate & ~prog_zero;
      POWER_FROM_ANALOG           <= gate & prog_zero & filt_q[hlci_pkg::IN_ANALOG];
      ANALOG_INPUT_ENABLE         <= gate & filt_q[hlci_pkg::IN_ANALOG];
      SOFTWARE_CONTROL            <= gate & filt_q[hlci_pkg::IN_INTCTL];
      GUIDE_LIGHT_ON              <= gate & filt_q[hlci_pkg::IN_GUIDE];
    end
  end

  // Flags driven straight from their flip-flops
  assign PROGRAM_RUNNING_OUTPUT      = (state_q == hlci_pkg::HLCI_RUN);
  assign PROGRAM_ENDED_OUTPUT        = ended_q;
  assign ABNORMAL_TERMINATION_OUTPUT = abn_q;
  assign ALARM_LATCHED               = alarm_q;

  logic                  aw_got_q;                 // Write address held
  logic                  w_got_q;                  // Write data held
  logic [ADDR_W-1:0]     awaddr_q;                 // Captured write address
  logic [31:0]           wdata_q;                  // Captured write data
  logic [3:0]            wstrb_q;                  // Captured strobes
  logic                  wr_fire;                  // Perform the write
  logic [2:0]            wsel;                     // Write register select
  logic [hlci_pkg::EV_W-1:0] events;               // Event pulses
  logic [hlci_pkg::EV_W-1:0] w1c;                  // Bits cleared by software
  logic [31:0]           status;                   // Live status word
  logic [31:0]           mask_new;                 // Mask word after a write merge

  assign wr_fire = aw_got_q & w_got_q & ~S_AXI_BVALID;
  assign wsel    = reg_sel(awaddr_q);
  assign events  = {alrst_rise, ev_fault, ev_stop, launch};
  assign w1c     = (wr_fire && wsel == 3'h2) ? (wdata_q[hlci_pkg::EV_W-1:0] & {4{wstrb_q[0]}})
                                              : 4'h0;
  assign status  = {12'h000, alarm_q, abn_q, ended_q, PROGRAM_RUNNING_OUTPUT, 2'h0, filt_q};
  // Merge kept as a word so that only the implemented mask bits are taken
  assign mask_new = merge({28'h0, irq_mask_q}, wdata_q, wstrb_q);

  // Write channel: address and data taken in either order
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= hlci_pkg::RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_got_q      <= 1'b1;
        awaddr_q      <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_got_q      <= 1'b1;
        wdata_q      <= S_AXI_WDATA;
        wstrb_q      <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wsel == 3'h4) ? hlci_pkg::RESP_SLVERR : hlci_pkg::RESP_OKAY;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      ctrl_q     <= hlci_pkg::CTRL_RST;
      irq_mask_q <= hlci_pkg::MASK_RST;
    end
    else if (wr_fire && wsel == 3'h0)
    begin
      ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0001;
    end
    else if (wr_fire && wsel == 3'h3)
    begin
      irq_mask_q <= mask_new[hlci_pkg::EV_W-1:0];
    end
  end

  // Sticky events, write one to clear, set wins; level interrupt
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      irq_stat_q <= '0;
      IRQ        <= 1'b0;
    end
    else
    begin
      irq_stat_q <= events | (irq_stat_q & ~w1c);
      IRQ        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read channel, one cycle to answer
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= hlci_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= hlci_pkg::RESP_OKAY;
      case (reg_sel(S_AXI_ARADDR))
        3'h0:    S_AXI_RDATA <= ctrl_q;
        3'h1:    S_AXI_RDATA <= status;
        3'h2:    S_AXI_RDATA <= {28'h0, irq_stat_q};
        3'h3:    S_AXI_RDATA <= {28'h0, irq_mask_q};
        default:
        begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= hlci_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Checks on the port behaviour
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  a_request_gate: assert property (!gate |=> !EMISSION_ENABLE && !GUIDE_LIGHT_ON)
    else $error("control acted on without request");
  a_plain_enable: assert property (start_lvl && prog_zero |=> EMISSION_ENABLE
    && !PROGRAM_RUNNING_OUTPUT)
    else $error("start with zero number did not enable emission");
  a_launch_edge: assert property (launch |=> PROGRAM_RUNNING_OUTPUT ##0 PROGRAM_LAUNCH)
    else $error("program not launched on start edge");
  a_power_source: assert property (gate |=> POWER_FROM_PROGRAM == !$past(prog_zero))
    else $error("power source does not follow program number");
  a_alarm_clear: assert property (alrst_rise && !ALARM_EVENT_IN |=> !ALARM_LATCHED)
    else $error("alarm not cleared by reset edge");
  a_guide_follow: assert property (gate && filt_q[hlci_pkg::IN_GUIDE] |=> GUIDE_LIGHT_ON)
    else $error("guide light not on");
  a_stop_now: assert property (PROGRAM_RUNNING_OUTPUT && gate
    && filt_q[hlci_pkg::IN_STOP] |=> !PROGRAM_RUNNING_OUTPUT && PROGRAM_ENDED_OUTPUT)
    else $error("stop input did not end program");
  a_run_start: assert property ($rose(PROGRAM_RUNNING_OUTPUT) |->
    $past(rise[hlci_pkg::IN_START]) && !$past(prog_zero))
    else $error("program running without launch");
  a_ended_clear: assert property (PROGRAM_ENDED_OUTPUT && !filt_q[hlci_pkg::IN_START]
    && !ev_stop |=> !PROGRAM_ENDED_OUTPUT)
    else $error("ended flag not cleared by start low");
  a_abn_clear: assert property (ABNORMAL_TERMINATION_OUTPUT && gate
    && filt_q[hlci_pkg::IN_ALRST] && !ev_fault |=> !ABNORMAL_TERMINATION_OUTPUT)
    else $error("abnormal flag not cleared");
  a_req_ack: assert property ($rose(gate) |=> REQUEST_ACKNOWLEDGE_OUTPUT)
    else $error("request not acknowledged");
  a_debounce_hold: assert property ($changed(filt_q) |->
    ((filt_q ^ $past(filt_q)) & ($past(s2_q) ^ $past(s3_q))) == '0)
    else $error("debounced level moved without agreement");

endmodule : hlci_top

// ---- tb/hlci_ctl_model.sv ----
`timescale 1ns/10ps
module hlci_ctl_model
#(
  parameter int PULSE_CYC = 50000 // Alarm reset width, 1 ms at 50 MHz
)
(
  input  wire logic clk,          // System clock
  input  wire logic start_req,    // Bench wants start held
  input  wire logic alrst_req,    // Bench asks for a reset pulse
  input  wire logic running,      // Program running indication
  output logic      start_line,   // Start pin
  output logic      alarm_reset   // Alarm reset pin
);
  int cnt;                        // Cycles left in the reset pulse

  initial
  begin
    start_line = 1'b0;
    cnt = 0;
  end

  // Start never drops while a program is running
  always @(posedge clk)
  begin
    if (start_req)
      start_line <= 1'b1;
    else if (!running)
      start_line <= 1'b0;
  end

  // Reset pulse held for the full width, retriggers only when idle
  always @(posedge clk)
  begin
    if (alrst_req && cnt == 0)
      cnt <= PULSE_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end

  assign alarm_reset = (cnt != 0);
endmodule : hlci_ctl_model

// ---- tb/hlci_top_tb.sv ----
`timescale 1ns/10ps
module hlci_top_tb;
  logic        clk_sys, rst_b;                      // Clock and reset
  logic        req, intc, guide, ana, stop;         // Level pins
  logic        done, fault, alev;                   // Engine events
  logic [6:0]  num, pnum, pn;                       // Program numbers
  logic        start_req, alrst_req, start_l, alrst_l; // Partner side
  logic        ack, run, ended, abn, emis, lnch, abrt;
  logic        pfp, pfa, aie, swc, glo, alm, irq;   // Internal controls
  logic [7:0]  awaddr, araddr;                      // Bus addresses
  logic [31:0] wdata, rdata;                        // Bus data
  logic [3:0]  wstrb;                               // Byte strobes
  logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [1:0]  bresp, rresp;                        // Bus answers
  int          errors, tests_run, seed;             // Bookkeeping

  hlci_top i_dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .REQUEST_LINE(req),
    .START_LINE(start_l), .INTERNAL_CONTROL_ENABLE(intc), .ALARM_RESET_INPUT(alrst_l),
    .GUIDE_LIGHT_INPUT(guide), .ANALOG_ENABLE(ana), .PROGRAM_STOP_INPUT(stop),
    .PROGRAM_SELECT_INPUTS(num), .PROG_DONE_IN(done), .PROG_FAULT_IN(fault),
    .ALARM_EVENT_IN(alev), .REQUEST_ACKNOWLEDGE_OUTPUT(ack), .PROGRAM_RUNNING_OUTPUT(run),
    .PROGRAM_ENDED_OUTPUT(ended), .ABNORMAL_TERMINATION_OUTPUT(abn), .EMISSION_ENABLE(emis),
    .PROGRAM_LAUNCH(lnch), .PROGRAM_ABORT(abrt), .PROGRAM_NUMBER(pnum),
    .POWER_FROM_PROGRAM(pfp), .POWER_FROM_ANALOG(pfa), .ANALOG_INPUT_ENABLE(aie),
    .SOFTWARE_CONTROL(swc), .GUIDE_LIGHT_ON(glo), .ALARM_LATCHED(alm), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));

  // Far-side controller for start and alarm reset pins
  hlci_ctl_model #(.PULSE_CYC(50000)) i_ctl (.clk(clk_sys), .start_req(start_req),
    .alrst_req(alrst_req), .running(run), .start_line(start_l), .alarm_reset(alrst_l));

  // Verdict and end of run
  task results;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // Compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // A wait ran out
  task fail(input string m);
    errors++;
    $display("wrong value at %0t: %s timeout", $time, m);
    results();
  endtask : fail

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // Bus write, address and data offered together
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    br <= 1'b0;
    if (n == 40) fail("write");
    chk(bresp, hlci_pkg::RESP_OKAY, "bresp");
  endtask : axw

  // Bus read and compare of data and answer
  task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string m);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    rr <= 1'b0;
    if (n == 40) fail(m);
    chk(rdata, e, m);
    chk(rresp, er, m);
  endtask : axr

  // Wait for the running output to reach a level
  task wait_run(input logic lvl);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_sys);
      if (run === lvl) break;
    end
    if (n == 40) fail("running");
  endtask : wait_run

  // Expected power source pair {program, analog}
  function logic [1:0] exp_pwr(input logic [6:0] p, input logic a);
    return {p != 7'h00, p == 7'h00 && a};
  endfunction : exp_pwr

  // Expected interrupt level
  function logic exp_irq(input logic [3:0] st, input logic [3:0] mk);
    return |(st & mk);
  endfunction : exp_irq

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    seed = 32'h55b5b428;
    {errors, tests_run} = '0;
    {rst_b, req, intc, guide, ana, stop, done, fault, alev, start_req, alrst_req} = '0;
    {num, awaddr, araddr, wdata, awv, wv, br, arv, rr} = '0;
    wstrb = 4'hF;
    tick(6);
    rst_b <= 1'b1;
    chk({ack, run, ended, abn, emis, irq, alm}, 32'h0, "reset outs");
    axr(hlci_pkg::OFF_CTRL, hlci_pkg::CTRL_RST, hlci_pkg::RESP_OKAY, "ctrl");
    axr(hlci_pkg::OFF_IRQ_MASK, 32'h0, hlci_pkg::RESP_OKAY, "mask");
    axr(8'h10, 32'h0, hlci_pkg::RESP_SLVERR, "unmapped");
    $display("test reset done");
    // Pins ignored without request, number zero, analog only then
    ana <= 1'b1;
    start_req <= 1'b1;
    tick(7);
    chk({emis, aie}, 32'h0, "gated");
    req <= 1'b1;
    guide <= 1'b1;
    intc <= 1'b1;
    tick(7);
    chk(ack, 1'b1, "ack");
    chk(emis, 1'b1, "emission");
    chk({pfp, pfa}, exp_pwr(7'h00, 1'b1), "pwr");
    chk(aie, 1'b1, "analog");
    chk(glo, 1'b1, "guide on");
    chk(swc, 1'b1, "software");
    {guide, intc, ana, start_req} <= 4'h0;
    tick(7);
    chk({glo, swc}, 32'h0, "guide off");
    $display("test levels done");
    // Launch, then normal end or stop, random and top-bit numbers
    axw(hlci_pkg::OFF_IRQ_MASK, 32'hF);
    for (int k = 0; k < 2; k++)
    begin
      pn = k ? 7'h40 : 7'($random(seed));
      if (pn == 7'h00) pn = 7'h01;
      num <= pn;
      tick(7);
      chk(pnum, pn, "number");
      chk({pfp, pfa}, exp_pwr(pn, 1'b0), "pwr");
      start_req <= 1'b1;
      wait_run(1'b1);
      chk(lnch, 1'b1, "launch");
      chk(emis, 1'b0, "no plain emission");
      @(posedge clk_sys);
      if (k == 0) done <= 1'b1;
      else stop <= 1'b1;
      @(posedge clk_sys);
      done <= 1'b0;
      wait_run(1'b0);
      chk(ended, 1'b1, "ended");
      axr(hlci_pkg::OFF_IRQ_STAT, 32'h3, hlci_pkg::RESP_OKAY, "stat");
      chk(irq, exp_irq(4'h3, 4'hF), "irq");
      axw(hlci_pkg::OFF_IRQ_STAT, 32'h3);
      tick(2);
      chk(irq, 1'b0, "irq clear");
      {stop, start_req} <= 2'h0;
      tick(7);
      chk(ended, 1'b0, "ended clear");
    end
    $display("test program done");
    // Fault, mask, then alarm reset pulse
    start_req <= 1'b1;
    wait_run(1'b1);
    @(posedge clk_sys);
    {fault, alev} <= 2'h3;
    @(posedge clk_sys);
    {fault, alev} <= 2'h0;
    @(posedge clk_sys);
    chk(abrt, 1'b1, "abort");
    tick(2);
    chk({abn, alm, run}, 32'h6, "fault");
    axw(hlci_pkg::OFF_IRQ_MASK, 32'h0);
    tick(2);
    chk(irq, 1'b0, "masked");
    axw(hlci_pkg::OFF_IRQ_MASK, 32'h4);
    tick(2);
    chk(irq, exp_irq(4'h5, 4'h4), "unmasked");
    alrst_req <= 1'b1;
    @(posedge clk_sys);
    alrst_req <= 1'b0;
    tick(8);
    chk(alm, 1'b0, "alarm clear");
    chk(abn, 1'b0, "abnormal clear");
    for (int n = 0; alrst_l !== 1'b0; n++)
    begin
      if (n > 60000) fail("pulse");
      @(posedge clk_sys);
    end
    axr(hlci_pkg::OFF_IRQ_STAT, 32'hD, hlci_pkg::RESP_OKAY, "stat alarm");
    axw(hlci_pkg::OFF_CTRL, 32'h0);
    tick(2);
    chk(ack, 1'b0, "port off");
    $display("test alarm done");
    results();
  end
endmodule : hlci_top_tb
